// ---- design/tpl_params.svh ----
// constants for the twisted-pair link, polarity and sleep controller
`ifndef TPL_PARAMS_SVH
`define TPL_PARAMS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define TPL_OFS_MODE 8'h00
`define TPL_OFS_TEST 8'h04
`define TPL_OFS_MISC 8'h08
`define TPL_OFS_LED 8'h0C
`define TPL_OFS_STAT 8'h10

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define TPL_MODE_PORT_LO 0
`define TPL_MODE_PORT_HI 1
`define TPL_MODE_LNKDIS 2
`define TPL_MODE_LOWTHR 3
`define TPL_TEST_BABBLE 1
`define TPL_MISC_WAKE 0
`define TPL_LED_LNKEN 0
`define TPL_LED_POLEN 1
`define TPL_STAT_INV 0
`define TPL_STAT_PASS 1
`define TPL_STAT_ARMED 2
`define TPL_STAT_SNOOZE 3
`define TPL_STAT_COMA 4

// -----------------------------------------------------------------
// reset values and codes
// -----------------------------------------------------------------
`define TPL_MODE_RST 4'h0
`define TPL_MISC_RST 1'h0
`define TPL_LED_RST 2'h0
`define TPL_PORT_TP 2'h1

// -----------------------------------------------------------------
// timing: figures as printed, counts derived in the module
// -----------------------------------------------------------------
`define TPL_CLK_HZ 25000000
`define TPL_PULSE_MIN_NS 60
`define TPL_PULSE_MAX_NS 200
`define TPL_BIT_NS 100
`define TPL_COL_EXT_BITS 2
`define TPL_PD_HOLD_US 10
`define TPL_JAB_MS 20
`define TPL_UNJAB_MS 250
`define TPL_LOSS_MS 100
`define TPL_LP_PERIOD_MS 16
`define TPL_PASS_PULSES 5
`define TPL_BLANK_CYC 8

`endif

// ---- design/tpl_pkg.sv ----
// types shared by the twisted-pair link, polarity and sleep controller
package tpl_pkg;

  typedef enum logic [1:0] {
    LS_RESET,
    LS_FAIL,
    LS_PASS
  } tpl_link_t;

  typedef enum logic [2:0] {
    SL_NETWORK_WAKE_ENABLE,
    SL_WAIT_GNT,
    SL_DROP,
    SL_SRST,
    SL_COMA,
    SL_SNOOZE
  } tpl_sleep_t;

endpackage : tpl_pkg

// ---- design/tpl_link_polarity_sleep_ctrl.sv ----
// twisted-pair link, receive polarity, jabber and sleep control
`timescale 1ns/1ps
`include "tpl_params.svh"

// Operation
// RQ1: arm polarity detection after hard reset or link fail entry.
// RQ2: in link fail accept both pulse signs; exit after 5 same-sign pulses.
// RQ3: link pass takes polarity of last pulses, then accepts only that sign.
// RQ4: a link pulse qualifies when its main excursion lasts 60 to 200 ns.
// RQ5: stay armed until two consecutive valid-delimiter frames agree.
// RQ6: first valid-delimiter frame sets polarity regardless of prior state.
// RQ7: agreement locks; disagreement adopts newest; invalid delimiters ignored.
// RQ8: once locked, detection stays off until link fail or hard reset.
// RQ9: inverted-input flag readable by software, routable to an LED.
// RQ10: start in link fail; selecting twisted pair forces fail; indicators off.
// RQ11: collision while both pairs active, extended two bit times after.
// RQ12: heartbeat test disabled while twisted pair is selected.
// RQ13: overlong transmission disables driver, sets lockout flag, asserts col.
// RQ14: after transmit removed, wait unjab time, then release and re-enable.
// RQ15: hard reset, coma or deselection reset and power down the transceiver.
// RQ16: after power-down ends hold reset 10 us, then link fail.
// RQ17: sleep pin low enters coma or snooze; register I/O gets aborted. The code aborts only mode and test register accesses.
// RQ18: snooze keeps reception, stops link pulses, only link output works.
// RQ19: snooze shows good link only when its LED enable bit is set.
// RQ20: with bus request active, wait grant, drop request, then sleep.
// RQ21: soft reset before sleep; configuration registers stay unchanged.
// RQ22: system asserts sleep no sooner than three clocks after reset.
// RQ23: with link check on, no pulses and no data causes link fail.
module tpl_link_polarity_sleep_ctrl #(
  parameter int JAB_MS = `TPL_JAB_MS,
  parameter int UNJAB_MS = `TPL_UNJAB_MS,
  parameter int LOSS_MS = `TPL_LOSS_MS,
  parameter int LP_PERIOD_MS = `TPL_LP_PERIOD_MS
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic wb_err_out,
  input wire logic rx_pos_in,
  input wire logic rx_neg_in,
  input wire logic rx_active_in,
  input wire logic rx_frame_end_in,
  input wire logic rx_delim_valid_in,
  input wire logic rx_delim_inv_in,
  input wire logic tx_request_in,
  input wire logic bus_want_in,
  input wire logic sleep_n_in,
  input wire logic gnt_n_in,
  output logic req_n_out,
  output logic tx_enable_out,
  output logic link_pulse_out,
  output logic rx_invert_out,
  output logic rx_enable_out,
  output logic rx_low_thresh_out,
  output logic tp_power_down_out,
  output logic heartbeat_test_en_out,
  output logic transmit_activity_out,
  output logic receive_activity_out,
  output logic collision_out,
  output logic link_good_output_out,
  output logic inverted_input_flag_out,
  output logic pol_led_out,
  output logic soft_reset_out
);

  // -----------------------------------------------------------------
  // derived cycle counts
  // -----------------------------------------------------------------
  localparam int CLK_KHZ = `TPL_CLK_HZ / 1000;
  localparam int PER_NS = 1000000000 / `TPL_CLK_HZ;
  localparam int PMIN_CYC = (`TPL_PULSE_MIN_NS + PER_NS - 1) / PER_NS;
  localparam int PMAX_CYC = `TPL_PULSE_MAX_NS / PER_NS;
  localparam int CEXT_CYC =
    (`TPL_COL_EXT_BITS * `TPL_BIT_NS + PER_NS - 1) / PER_NS;
  localparam int HOLD_CYC = `TPL_PD_HOLD_US * (CLK_KHZ / 1000);
  localparam int JAB_CYC = JAB_MS * CLK_KHZ;
  localparam int UNJAB_CYC = UNJAB_MS * CLK_KHZ;
  localparam int LOSS_CYC = LOSS_MS * CLK_KHZ;
  localparam int LP_CYC = LP_PERIOD_MS * CLK_KHZ;

  // -----------------------------------------------------------------
  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  // -----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] pin_q;

  assign pin_raw = {gnt_n_in, sleep_n_in, rx_neg_in, rx_pos_in};

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sync1_q <= 4'hC;
      sync2_q <= 4'hC;
      sync3_q <= 4'hC;
      pin_q <= 4'hC;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 4; i++)
      begin
        if (sync2_q[i] == sync3_q[i])
          pin_q[i] <= sync3_q[i];
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [3:0] mode_reg_q;
  logic babble_lockout_flag_q;
  logic network_wake_enable_q;
  logic [1:0] led_config_reg_q;
  logic wb_req;
  logic wb_wr;
  logic csr_hit;
  logic asleep;
  logic tp_sel;
  logic pd;
  logic jab_set;
  tpl_pkg::tpl_sleep_t sleep_q;
  tpl_pkg::tpl_link_t link_q;
  logic inv_q;
  logic armed_q;

  assign tp_sel = mode_reg_q[`TPL_MODE_PORT_HI:`TPL_MODE_PORT_LO]
                  == `TPL_PORT_TP;
  assign asleep = sleep_q != tpl_pkg::SL_NETWORK_WAKE_ENABLE;
  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
  assign wb_wr = wb_req & wb_we_in & wb_sel_in[0];
  assign csr_hit = wb_adr_in == `TPL_OFS_MODE
                   || wb_adr_in == `TPL_OFS_TEST;

  // soft reset clears only the lockout flag
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      mode_reg_q <= `TPL_MODE_RST;
    else if (wb_wr && !asleep && wb_adr_in == `TPL_OFS_MODE)
      mode_reg_q <= wb_dat_in[3:0];
  end

  // lockout flag: hardware set wins over write-one-to-clear
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || soft_reset_out)
      babble_lockout_flag_q <= 1'h0;
    else if (jab_set)
      babble_lockout_flag_q <= 1'h1; // [RQ13]
    else if (wb_wr && !asleep && wb_adr_in == `TPL_OFS_TEST
             && wb_dat_in[`TPL_TEST_BABBLE])
      babble_lockout_flag_q <= 1'h0;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      network_wake_enable_q <= `TPL_MISC_RST;
      led_config_reg_q <= `TPL_LED_RST;
    end
    else if (wb_wr && wb_adr_in == `TPL_OFS_MISC)
      network_wake_enable_q <= wb_dat_in[`TPL_MISC_WAKE];
    else if (wb_wr && wb_adr_in == `TPL_OFS_LED)
      led_config_reg_q <= wb_dat_in[1:0];
  end

  // -----------------------------------------------------------------
  // wishbone answer: one cycle after the request, mode and test accesses aborted while asleep
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wb_ack_out <= 1'h0;
      wb_err_out <= 1'h0;
      wb_dat_out <= 32'h0;
    end
    else
    begin
      wb_ack_out <= wb_req && !(asleep && csr_hit);
      wb_err_out <= wb_req && asleep && csr_hit; // [RQ17]
      wb_dat_out <= 32'h0;
      if (wb_req && !wb_we_in && !(asleep && csr_hit))
      begin
        unique case (wb_adr_in)
          `TPL_OFS_MODE: wb_dat_out[3:0] <= mode_reg_q;
          `TPL_OFS_TEST:
            wb_dat_out[`TPL_TEST_BABBLE] <= babble_lockout_flag_q;
          `TPL_OFS_MISC:
            wb_dat_out[`TPL_MISC_WAKE] <= network_wake_enable_q;
          `TPL_OFS_LED: wb_dat_out[1:0] <= led_config_reg_q;
          `TPL_OFS_STAT:
          begin
            wb_dat_out[`TPL_STAT_INV] <= inv_q; // [RQ9]
            wb_dat_out[`TPL_STAT_PASS] <= link_q == tpl_pkg::LS_PASS;
            wb_dat_out[`TPL_STAT_ARMED] <= armed_q;
            wb_dat_out[`TPL_STAT_SNOOZE] <= sleep_q == tpl_pkg::SL_SNOOZE;
            wb_dat_out[`TPL_STAT_COMA] <= sleep_q == tpl_pkg::SL_COMA;
          end
          default: wb_dat_out <= 32'h0;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // sleep sequencing
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      sleep_q <= tpl_pkg::SL_NETWORK_WAKE_ENABLE;
    else
    begin
      unique case (sleep_q)
        tpl_pkg::SL_NETWORK_WAKE_ENABLE:
          if (!pin_q[2])
            sleep_q <= !req_n_out ? tpl_pkg::SL_WAIT_GNT
                                  : tpl_pkg::SL_SRST;
        tpl_pkg::SL_WAIT_GNT:
          if (!pin_q[3])
            sleep_q <= tpl_pkg::SL_DROP; // [RQ20]
        tpl_pkg::SL_DROP:
          sleep_q <= tpl_pkg::SL_SRST;
        tpl_pkg::SL_SRST:
          sleep_q <= (network_wake_enable_q && tp_sel)
                     ? tpl_pkg::SL_SNOOZE : tpl_pkg::SL_COMA; // [RQ18]
        tpl_pkg::SL_COMA, tpl_pkg::SL_SNOOZE:
          if (pin_q[2])
            sleep_q <= tpl_pkg::SL_NETWORK_WAKE_ENABLE;
        default: sleep_q <= tpl_pkg::SL_NETWORK_WAKE_ENABLE;
      endcase
    end
  end

  // request is dropped once the grant arrives and held off while asleep
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      req_n_out <= 1'h1;
    else if (sleep_q == tpl_pkg::SL_WAIT_GNT)
      req_n_out <= pin_q[3] ? 1'h0 : 1'h1; // [RQ20]
    else
      req_n_out <= !(bus_want_in && sleep_q == tpl_pkg::SL_NETWORK_WAKE_ENABLE
                     && (pin_q[2] || !req_n_out));
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      soft_reset_out <= 1'h0;
    else
      soft_reset_out <= sleep_q == tpl_pkg::SL_DROP
                        || (sleep_q == tpl_pkg::SL_NETWORK_WAKE_ENABLE && !pin_q[2]
                            && req_n_out); // [RQ21]
  end

  // -----------------------------------------------------------------
  // power down and reset hold
  // -----------------------------------------------------------------
  logic [7:0] hold_q;
  logic in_fail_entry;

  assign pd = sleep_q == tpl_pkg::SL_COMA || !tp_sel; // [RQ15]

  // -----------------------------------------------------------------
  // link pulse qualifier, one lane per sign
  // -----------------------------------------------------------------
  logic [1:0] pulse_ok;
  logic [3:0] blank_q;

  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    logic lvl_q;
    logic [2:0] wid_q;

    always_ff @(posedge clk_in)
    begin
      if (sys_rst_in || pd)
      begin
        lvl_q <= 1'h0;
        wid_q <= 3'h0;
      end
      else
      begin
        lvl_q <= pin_q[g];
        if (pin_q[g] && wid_q != 3'h7)
          wid_q <= wid_q + 3'h1;
        else if (!pin_q[g])
          wid_q <= 3'h0;
      end
    end

    // excursion ends: width must sit inside the allowed window
    assign pulse_ok[g] = lvl_q && !pin_q[g]
                         && int'(wid_q) >= PMIN_CYC
                         && int'(wid_q) <= PMAX_CYC
                         && (blank_q == 4'h0); // [RQ4]
  end

  // a trailing opposite excursion must not count as a second pulse
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd)
      blank_q <= 4'h0;
    else if (|pulse_ok)
      blank_q <= 4'(`TPL_BLANK_CYC);
    else if (blank_q != 4'h0 && !pin_q[0] && !pin_q[1])
      blank_q <= blank_q - 4'h1;
  end

  // -----------------------------------------------------------------
  // link state
  // -----------------------------------------------------------------
  logic [2:0] run_q;
  logic run_inv_q;
  logic pulse_any;
  logic pulse_inv;
  logic [23:0] loss_q;
  logic frame_ok;
  logic link_ok;

  assign pulse_any = |pulse_ok;
  assign pulse_inv = pulse_ok[1];
  assign frame_ok = rx_frame_end_in && rx_delim_valid_in;
  assign in_fail_entry = link_q == tpl_pkg::LS_PASS && !mode_reg_q[2]
                         && int'(loss_q) >= LOSS_CYC - 1; // [RQ23]
  assign link_ok = link_q == tpl_pkg::LS_PASS
                   || (link_q == tpl_pkg::LS_FAIL && mode_reg_q[2]);

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd)
    begin
      link_q <= tpl_pkg::LS_RESET; // [RQ15]
      hold_q <= 8'h0;
      run_q <= 3'h0;
      run_inv_q <= 1'h0;
    end
    else
    begin
      unique case (link_q)
        tpl_pkg::LS_RESET:
        begin
          hold_q <= hold_q + 8'h1;
          if (int'(hold_q) >= HOLD_CYC - 1)
            link_q <= tpl_pkg::LS_FAIL; // [RQ16] [RQ10]
        end
        tpl_pkg::LS_FAIL:
        begin
          if (pulse_any)
          begin
            run_inv_q <= pulse_inv; // [RQ2]
            run_q <= (run_q != 3'h0 && pulse_inv == run_inv_q)
                     ? run_q + 3'h1 : 3'h1;
            if (run_q == 3'(`TPL_PASS_PULSES - 1)
                && pulse_inv == run_inv_q)
              link_q <= tpl_pkg::LS_PASS; // [RQ2]
          end
          else if (frame_ok)
            link_q <= tpl_pkg::LS_PASS; // [RQ16]
        end
        tpl_pkg::LS_PASS:
        begin
          run_q <= 3'h0;
          if (in_fail_entry)
            link_q <= tpl_pkg::LS_FAIL; // [RQ23]
        end
        default: link_q <= tpl_pkg::LS_RESET;
      endcase
    end
  end

  // link loss timer restarts on pulses of the accepted sign or data
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd || link_q != tpl_pkg::LS_PASS)
      loss_q <= 24'h0;
    else if ((pulse_any && pulse_inv == inv_q) || rx_active_in) // [RQ3]
      loss_q <= 24'h0;
    else if (!in_fail_entry)
      loss_q <= loss_q + 24'h1;
    else
      loss_q <= 24'h0;
  end

  // -----------------------------------------------------------------
  // receive polarity
  // -----------------------------------------------------------------
  logic etd_seen_q;
  logic etd_inv_q;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd || link_q == tpl_pkg::LS_FAIL)
    begin
      armed_q <= 1'h1; // [RQ1] [RQ8]
      etd_seen_q <= 1'h0;
      etd_inv_q <= 1'h0;
    end
    else if (armed_q && frame_ok)
    begin
      etd_seen_q <= 1'h1;
      etd_inv_q <= rx_delim_inv_in; // [RQ7]
      if (etd_seen_q && rx_delim_inv_in == etd_inv_q)
        armed_q <= 1'h0; // [RQ5] [RQ8]
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd)
      inv_q <= 1'h0;
    else if (link_q == tpl_pkg::LS_FAIL && pulse_any
             && run_q == 3'(`TPL_PASS_PULSES - 1)
             && pulse_inv == run_inv_q)
      inv_q <= pulse_inv; // [RQ3] [RQ1]
    else if (armed_q && frame_ok)
      inv_q <= rx_delim_inv_in; // [RQ6] [RQ7]
  end

  // -----------------------------------------------------------------
  // jabber and collision
  // -----------------------------------------------------------------
  logic [23:0] jab_q;
  logic jabbed_q;
  logic [2:0] cext_q;
  logic both_act;

  assign jab_set = !jabbed_q && tx_request_in && link_ok
                   && int'(jab_q) >= JAB_CYC - 1;
  assign both_act = link_ok && tx_request_in && rx_active_in && !jabbed_q;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd)
    begin
      jab_q <= 24'h0;
      jabbed_q <= 1'h0;
    end
    else if (!jabbed_q)
    begin
      jab_q <= (tx_request_in && link_ok) ? jab_q + 24'h1 : 24'h0;
      if (jab_set)
      begin
        jabbed_q <= 1'h1; // [RQ13]
        jab_q <= 24'h0;
      end
    end
    else if (tx_request_in)
      jab_q <= 24'h0;
    else if (int'(jab_q) >= UNJAB_CYC - 1)
    begin
      jabbed_q <= 1'h0; // [RQ14]
      jab_q <= 24'h0;
    end
    else
      jab_q <= jab_q + 24'h1;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd)
      cext_q <= 3'h0;
    else if (both_act)
      cext_q <= 3'(CEXT_CYC); // [RQ11]
    else if (cext_q != 3'h0)
      cext_q <= cext_q - 3'h1;
  end

  // -----------------------------------------------------------------
  // link pulse generator
  // -----------------------------------------------------------------
  logic [23:0] lp_q;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || pd || sleep_q == tpl_pkg::SL_SNOOZE
        || tx_request_in) // [RQ18]
      lp_q <= 24'h0;
    else if (int'(lp_q) >= LP_CYC - 1)
      lp_q <= 24'h0;
    else
      lp_q <= lp_q + 24'h1;
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  logic live;

  assign live = !pd && sleep_q != tpl_pkg::SL_SNOOZE;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      tx_enable_out <= 1'h0;
      link_pulse_out <= 1'h0;
      rx_invert_out <= 1'h0;
      rx_enable_out <= 1'h0;
      rx_low_thresh_out <= 1'h0;
      tp_power_down_out <= 1'h1;
      heartbeat_test_en_out <= 1'h1;
      transmit_activity_out <= 1'h0;
      receive_activity_out <= 1'h0;
      collision_out <= 1'h0;
      link_good_output_out <= 1'h0;
      inverted_input_flag_out <= 1'h0;
      pol_led_out <= 1'h0;
    end
    else
    begin
      tx_enable_out <= live && link_ok && !jabbed_q && tx_request_in;
      link_pulse_out <= live && int'(lp_q) == LP_CYC - 1;
      rx_invert_out <= !pd && inv_q;
      rx_enable_out <= !pd; // [RQ18]
      rx_low_thresh_out <= mode_reg_q[`TPL_MODE_LOWTHR];
      tp_power_down_out <= pd; // [RQ15]
      heartbeat_test_en_out <= !tp_sel; // [RQ12]
      transmit_activity_out <= live && link_ok && tx_request_in; // [RQ10]
      receive_activity_out <= live && link_ok && rx_active_in;
      collision_out <= live && (both_act || cext_q != 3'h0
                                || jabbed_q); // [RQ11] [RQ13] [RQ14]
      link_good_output_out <= !pd && link_q == tpl_pkg::LS_PASS
                              && (sleep_q != tpl_pkg::SL_SNOOZE
                                  || led_config_reg_q[0]); // [RQ19]
      inverted_input_flag_out <= live && inv_q; // [RQ9]
      pol_led_out <= live && inv_q && led_config_reg_q[1];
    end
  end

endmodule : tpl_link_polarity_sleep_ctrl

// ---- testbench/tpl_chk_sva.sv ----
// port assertions for the link, polarity and sleep controller
`timescale 1ns/1ps
module tpl_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic wb_err_out,
  input wire logic rx_active_in,
  input wire logic tx_request_in,
  input wire logic req_n_out,
  input wire logic tx_enable_out,
  input wire logic tp_power_down_out,
  input wire logic collision_out,
  input wire logic link_good_output_out,
  input wire logic inverted_input_flag_out,
  input wire logic pol_led_out,
  input wire logic soft_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_bus_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    && !wb_err_out |=> wb_ack_out || wb_err_out)
    else $error("bus request not answered");
  a_abort_data: assert property (
    wb_err_out |-> wb_dat_out == 32'h0 && !wb_ack_out)
    else $error("abort with data or ack");
  a_pd_quiet: assert property (
    tp_power_down_out && $past(tp_power_down_out) |-> !tx_enable_out
    && !link_good_output_out && !inverted_input_flag_out && !collision_out)
    else $error("powered down with live outputs");
  a_col_cause: assert property (
    $rose(collision_out) |-> $past(tx_request_in))
    else $error("collision without transmit");
  a_col_hold: assert property (
    $fell(tx_request_in && rx_active_in) && collision_out && tx_enable_out
    |-> collision_out [*4])
    else $error("collision not extended");
  a_srst_req: assert property (
    soft_reset_out |-> req_n_out ##1 !soft_reset_out)
    else $error("soft reset with request held");
  a_pass_delay: assert property (
    $fell(tp_power_down_out) |-> !link_good_output_out [*8])
    else $error("link pass too soon after power up");
  a_pol_led: assert property (
    pol_led_out |-> inverted_input_flag_out || $past(inverted_input_flag_out))
    else $error("polarity led without flag");
  c_pass: cover property ($rose(link_good_output_out));
  c_srst: cover property (soft_reset_out);
  c_abort: cover property (wb_err_out);
endmodule : tpl_chk
bind tpl_link_polarity_sleep_ctrl tpl_chk u_chk (.*);

// ---- testbench/tpl_node_model.sv ----
// remote twisted-pair node: link pulses, carrier and frame ends
`timescale 1ns/1ps
module tpl_node_model (
  input wire logic clk_in,
  output logic pos_out,
  output logic neg_out,
  output logic act_out,
  output logic end_out,
  output logic valid_out,
  output logic inv_out
);
  initial
  begin
    {pos_out, neg_out, act_out, end_out, valid_out, inv_out} = 6'h00;
  end
  // 120 ns excursion then a quiet gap
  task automatic pulse(input logic neg);
    @(posedge clk_in);
    pos_out <= !neg;
    neg_out <= neg;
    repeat (3) @(posedge clk_in);
    pos_out <= 1'b0;
    neg_out <= 1'b0;
    repeat (20) @(posedge clk_in);
  endtask : pulse
  // qualifiers show the inverse once the frame end has passed
  task automatic frame(input logic valid, input logic inv, input int n);
    @(posedge clk_in);
    act_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    act_out <= 1'b0;
    end_out <= 1'b1;
    valid_out <= valid;
    inv_out <= inv;
    @(posedge clk_in);
    end_out <= 1'b0;
    valid_out <= !valid;
    inv_out <= !inv;
    repeat (20) @(posedge clk_in);
  endtask : frame
endmodule : tpl_node_model

// ---- testbench/testbench.sv ----
// self-checking bench for the link, polarity and sleep controller
`timescale 1ns/1ps
module testbench;
  logic clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, tx_request_in;
  logic bus_want_in, sleep_n_in, gnt_n_in, wb_ack_out, wb_err_out, e;
  logic rx_pos_in, rx_neg_in, rx_active_in, rx_frame_end_in;
  logic rx_delim_valid_in, rx_delim_inv_in, req_n_out, tx_enable_out;
  logic link_pulse_out, rx_invert_out, rx_enable_out, rx_low_thresh_out;
  logic tp_power_down_out, heartbeat_test_en_out, transmit_activity_out;
  logic receive_activity_out, collision_out, link_good_output_out;
  logic inverted_input_flag_out, pol_led_out, soft_reset_out;
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  int err_count, check_count, cyc_n;
  tpl_link_polarity_sleep_ctrl #(.JAB_MS(1), .UNJAB_MS(1), .LOSS_MS(1))
    uut (.*);
  tpl_node_model node (.clk_in(clk_in), .pos_out(rx_pos_in),
    .neg_out(rx_neg_in), .act_out(rx_active_in), .end_out(rx_frame_end_in),
    .valid_out(rx_delim_valid_in), .inv_out(rx_delim_inv_in));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_sel_in <= {4{w}};
    wb_adr_in <= a;
    wb_dat_in <= d;
    do
      @(posedge clk_in);
    while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1);
    rd = wb_dat_out;
    e = wb_err_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, rd & m);
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = !clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc_n++;
    if (cyc_n == 95000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    {sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in} = 12'h800;
    {tx_request_in, bus_want_in, wb_dat_in} = 34'h0;
    sleep_n_in = 1'b1;
    gnt_n_in = 1'b1;
    tick(3);
    sys_rst_in <= 1'b0;
    chk("power_down", 1, tp_power_down_out);
    chk("heartbeat", 1, heartbeat_test_en_out);
    rdc(8'h00, 32'h0, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, 8'h00, 32'h1);
    tick(260);
    chk("heartbeat", 0, heartbeat_test_en_out);
    chk("link", 0, link_good_output_out);
    repeat (4) node.pulse(1'b1);
    chk("link", 0, link_good_output_out);
    node.pulse(1'b1);
    chk("link", 1, link_good_output_out);
    repeat (5) node.pulse(1'b0);
    chk("inverted", 1, inverted_input_flag_out);
    rdc(8'h10, 32'h7, 32'h1F);
    wb(1'b1, 8'h0C, 32'h2);
    node.frame(1'b0, 1'b0, 8);
    chk("inverted", 1, inverted_input_flag_out);
    chk("pol_led", 1, pol_led_out);
    node.frame(1'b1, 1'b0, 8);
    chk("inverted", 0, inverted_input_flag_out);
    node.frame(1'b1, 1'b1, 8);
    rdc(8'h10, 32'h7, 32'h1F);
    node.frame(1'b1, 1'b1, 8);
    node.frame(1'b1, 1'b0, 8);
    rdc(8'h10, 32'h3, 32'h1F);
    $display("test polarity done");
    tx_request_in <= 1'b1;
    fork
      node.frame(1'b0, 1'b0, 12);
    join_none
    tick(6);
    chk("collision", 1, collision_out);
    tick(10);
    chk("collision", 1, collision_out);
    tick(6);
    chk("collision", 0, collision_out);
    tx_request_in <= 1'b0;
    wb(1'b1, 8'h00, 32'h5);
    tick(30);
    tx_request_in <= 1'b1;
    tick(25100);
    chk("collision", 1, collision_out);
    chk("tx_enable", 0, tx_enable_out);
    rdc(8'h04, 32'h2, 32'hFFFFFFFF);
    tx_request_in <= 1'b0;
    tick(25100);
    chk("collision", 0, collision_out);
    tx_request_in <= 1'b1;
    tick(4);
    chk("tx_enable", 1, tx_enable_out);
    tx_request_in <= 1'b0;
    $display("test jabber done");
    wb(1'b1, 8'h00, 32'h1);
    tick(25100);
    rdc(8'h10, 32'h4, 32'h6);
    node.frame(1'b1, 1'b0, 8);
    chk("link", 1, link_good_output_out);
    wb(1'b1, 8'h08, 32'h1);
    bus_want_in <= 1'b1;
    tick(5);
    sleep_n_in <= 1'b0;
    tick(20);
    chk("req_n", 0, req_n_out);
    gnt_n_in <= 1'b0;
    for (int i = 0; i < 40 && soft_reset_out !== 1'b1; i++) tick(1);
    chk("soft_reset", 1, soft_reset_out);
    chk("req_n", 1, req_n_out);
    {bus_want_in, gnt_n_in} <= 2'h1;
    rdc(8'h10, 32'h8, 32'h18);
    chk("link", 0, link_good_output_out);
    chk("rx_enable", 1, rx_enable_out);
    rdc(8'h08, 32'h1, 32'hFFFFFFFF);
    wb(1'b0, 8'h00, 32'h0);
    chk("abort", 1, e);
    sleep_n_in <= 1'b1;
    tick(10);
    wb(1'b1, 8'h08, 32'h0);
    sleep_n_in <= 1'b0;
    tick(20);
    rdc(8'h10, 32'h10, 32'h18);
    chk("power_down", 1, tp_power_down_out);
    $display("test sleep done");
    finish_test();
  end
endmodule : testbench
